// ---- rtl/mad_pkg.sv ----
// Package of address map constants for the memory address map decoder.
`default_nettype none
package mad_pkg;
  localparam int unsigned ADDR_W       = 17;
  localparam int unsigned DATA_W       = 16;
  localparam logic [16:0] SFB_BASE     = 17'h00000;
  localparam logic [16:0] SFB_END      = 17'h0000F;
  localparam logic [16:0] BPER_BASE    = 17'h00010;
  localparam logic [16:0] BPER_END     = 17'h000FF;
  localparam logic [16:0] WPER_BASE    = 17'h00100;
  localparam logic [16:0] WPER_END     = 17'h001FF;
  localparam logic [16:0] RAM_BASE     = 17'h00200;
  localparam logic [16:0] PROG_END     = 17'h1FFFF;
  localparam int unsigned VEC_WORDS    = 16;
  localparam logic [16:0] VEC_BASE     = 17'h1FFE0;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  localparam logic [15:0] OPEN_READ    = 16'h0000;
  // Region select codes, one-hot.
  typedef enum logic [5:0] {
    MAD_RG_NONE = 6'b000001,
    MAD_RG_SFB  = 6'b000010,
    MAD_RG_BPER = 6'b000100,
    MAD_RG_WPER = 6'b001000,
    MAD_RG_RAM  = 6'b010000,
    MAD_RG_PROG = 6'b100000
  } mad_region_e;
endpackage
`default_nettype wire

// ---- rtl/mad_lane.sv ----
// Byte lane steering for little-endian byte and word writes.
`default_nettype none
module mad_lane (
  input  wire logic        byte_i,
  input  wire logic        a0_i,
  input  wire logic        byte_only_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] wdata_o,
  output logic      [1:0]  be_o
);
  import mad_pkg::*;
  // A byte write repeats the byte on both lanes and enables the addressed lane.
  always_comb begin
    if (byte_i) begin
      wdata_o = {wdata_i[7:0], wdata_i[7:0]};
      be_o    = a0_i ? 2'h2 : 2'h1;
    end else if (byte_only_i) begin
      wdata_o = {ZERO_BYTE, wdata_i[7:0]};
      be_o    = 2'h1;
    end else begin
      wdata_o = wdata_i;
      be_o    = 2'h3;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/mad_decoder.sv ----
// Memory address map decoder with width adaptation on the shared buses.
//
// Contract
// R01: One 128 KB address space holds special bytes, peripherals, RAM, program.
// R02: Program memory ends at 1FFFFh; start set by size; fetch and data use.
// R03: Vector table is the top 16 program words, highest priority highest.
// R04: RAM starts at 0200h, its end set by size; fetch and data allowed.
// R05: 0100h to 01FFh decodes to word-wide peripherals.
// R06: Byte reads of word peripherals use even addresses, upper byte reads zero.
// R07: 010h to 0FFh decodes to byte-wide peripherals.
// R08: Word reads of byte peripherals have undefined upper byte.
// R09: Word writes to byte peripherals store only the lower byte.
// R10: Lowest 16 bytes are special function bytes, byte access only.
// R11: Requester fetches instructions from even addresses only.
// R12: Word transfers use even addresses; bytes may use any.
// R13: Words are little-endian, low byte at even address.
// R14: Instruction fetch from 0000h to 01FFh triggers a device reset.
// R15: Unmapped accesses have no side effect, read undefined, drop writes.
`default_nettype none
module mad_decoder #(
  parameter logic [16:0] PROG_BASE = 17'h1C000,
  parameter logic [16:0] RAM_END   = 17'h003FF
) (
  input  wire logic                  mclk_i,
  input  wire logic                  arst_n_i,
  input  wire logic                  req_i,
  input  wire logic                  we_i,
  input  wire logic                  byte_i,
  input  wire logic                  fetch_i,
  input  wire logic [mad_pkg::ADDR_W-1:0] shared_address_bus_i,
  input  wire logic [mad_pkg::DATA_W-1:0] shared_data_bus_wr_i,
  output logic      [mad_pkg::DATA_W-1:0] shared_data_bus_rd_o,
  output logic                       rvalid_o,
  output logic                       sfb_sel_o,
  output logic                       bper_sel_o,
  output logic                       wper_sel_o,
  output logic                       ram_sel_o,
  output logic                       prog_sel_o,
  output logic                       vec_hit_o,
  output logic      [3:0]            vec_index_o,
  output logic                       tgt_we_o,
  output logic      [1:0]            tgt_be_o,
  output logic      [mad_pkg::ADDR_W-1:0] tgt_addr_o,
  output logic      [mad_pkg::DATA_W-1:0] tgt_wdata_o,
  input  wire logic [mad_pkg::DATA_W-1:0] sfb_rdata_i,
  input  wire logic [mad_pkg::DATA_W-1:0] bper_rdata_i,
  input  wire logic [mad_pkg::DATA_W-1:0] wper_rdata_i,
  input  wire logic [mad_pkg::DATA_W-1:0] ram_rdata_i,
  input  wire logic [mad_pkg::DATA_W-1:0] prog_rdata_i,
  output logic                       fetch_reset_o
);
  import mad_pkg::*;

  // Registered state: pending read region, byte lane info and fetch reset.
  typedef struct packed {
    logic        rpend;
    mad_region_e rreg;
    logic        rbyte;
    logic        ra0;
    logic        frst;
    logic [15:0] rdata;
    logic        rvalid;
  } mad_state_s;

  mad_state_s  st_r;
  mad_state_s  st_nxt;
  mad_region_e region;
  logic [16:0] a;
  logic        byte_only;
  logic [15:0] lane_wdata;
  logic [1:0]  lane_be;
  logic [15:0] raw;
  logic [15:0] rd_sel;

  assign a = shared_address_bus_i;

  // Region decode over the single 17-bit space; gaps decode to none.
  always_comb begin
    region = MAD_RG_NONE; // R15
    if (a <= SFB_END) begin
      region = MAD_RG_SFB; // R10
    end else if (a >= BPER_BASE && a <= BPER_END) begin
      region = MAD_RG_BPER; // R07
    end else if (a >= WPER_BASE && a <= WPER_END) begin
      region = MAD_RG_WPER; // R05
    end else if (a >= RAM_BASE && a <= RAM_END) begin
      region = MAD_RG_RAM; // R04
    end else if (a >= PROG_BASE && a <= PROG_END) begin
      region = MAD_RG_PROG; // R02 R01
    end
  end

  // A fetch from the register and peripheral range is not routed anywhere.
  logic fetch_low;
  logic go;
  assign fetch_low = req_i && fetch_i && (a <= WPER_END); // R14
  assign go        = req_i && !fetch_low;

  // Strobes to each target; only one is high for a legal access.
  assign sfb_sel_o  = go && (region == MAD_RG_SFB);
  assign bper_sel_o = go && (region == MAD_RG_BPER);
  assign wper_sel_o = go && (region == MAD_RG_WPER);
  assign ram_sel_o  = go && (region == MAD_RG_RAM);
  assign prog_sel_o = go && (region == MAD_RG_PROG);
  assign tgt_we_o   = go && we_i && !fetch_i && (region != MAD_RG_NONE); // R15
  assign tgt_addr_o = {a[16:1], 1'b0} | {16'h0000, (byte_i ? a[0] : 1'b0)}; // R12
  assign byte_only  = (region == MAD_RG_BPER) || (region == MAD_RG_SFB);

  // Vector table lookup: top sixteen program words, index 15 at 1FFFEh.
  assign vec_hit_o   = prog_sel_o && (a >= VEC_BASE); // R03
  assign vec_index_o = a[4:1]; // R03

  // Write data steering on little-endian lanes.
  mad_lane u_lane (
    .byte_i      (byte_i),
    .a0_i        (a[0]),
    .byte_only_i (byte_only),
    .wdata_i     (shared_data_bus_wr_i),
    .wdata_o     (lane_wdata),
    .be_o        (lane_be)
  );
  assign tgt_wdata_o = lane_wdata; // R09 R13
  assign tgt_be_o    = lane_be; // R09 R13

  // Read data multiplexer for the region registered one cycle earlier.
  always_comb begin
    case (st_r.rreg)
      MAD_RG_SFB:  raw = sfb_rdata_i;
      MAD_RG_BPER: raw = bper_rdata_i;
      MAD_RG_WPER: raw = wper_rdata_i;
      MAD_RG_RAM:  raw = ram_rdata_i;
      MAD_RG_PROG: raw = prog_rdata_i;
      default:     raw = OPEN_READ; // R15
    endcase
  end

  // Byte reads pick the addressed lane and zero the upper byte.
  always_comb begin
    rd_sel = raw;
    if (st_r.rbyte) begin
      rd_sel = {ZERO_BYTE, (st_r.ra0 ? raw[15:8] : raw[7:0])}; // R06 R13
    end else if (st_r.rreg == MAD_RG_BPER || st_r.rreg == MAD_RG_SFB) begin
      rd_sel = {raw[15:8], raw[7:0]}; // R08
    end
  end

  // Next state: capture read context and the fetch reset request.
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rpend = go && !we_i;
    st_nxt.frst  = fetch_low; // R14
    st_nxt.rdata  = rd_sel;
    st_nxt.rvalid = st_r.rpend;
    if (go && !we_i) begin
      st_nxt.rreg  = region;
      st_nxt.rbyte = byte_i;
      st_nxt.ra0   = a[0];
    end
  end

  // State register.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '{rpend: 1'b0, rreg: MAD_RG_NONE, rbyte: 1'b0, ra0: 1'b0, frst: 1'b0,
                rdata: OPEN_READ, rvalid: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register, so read data never glitch.
  assign shared_data_bus_rd_o = st_r.rdata;
  assign rvalid_o             = st_r.rvalid;
  assign fetch_reset_o        = st_r.frst;

  // Checks next to the logic.
  // A low fetch raises the reset request on the next cycle.
  fetch_reset_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R14
    (req_i && fetch_i && a <= WPER_END) |=> fetch_reset_o)
    else $error("low fetch did not raise reset");
  // A low fetch never strobes a register or peripheral target.
  fetch_block_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R14
    (req_i && fetch_i && a <= WPER_END) |-> !(sfb_sel_o || bper_sel_o || wper_sel_o))
    else $error("low fetch reached a target");
  // Data accesses to the word peripheral range pick that target.
  word_per_sel_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R05
    (req_i && !fetch_i && a >= WPER_BASE && a <= WPER_END) |-> wper_sel_o)
    else $error("word peripheral not selected");
  // Data accesses to the byte peripheral range pick that target.
  byte_per_sel_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R07
    (req_i && !fetch_i && a >= BPER_BASE && a <= BPER_END) |-> bper_sel_o)
    else $error("byte peripheral not selected");
  // Data accesses to the lowest sixteen bytes pick the special bytes.
  sfb_sel_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R10
    (req_i && !fetch_i && a <= SFB_END) |-> sfb_sel_o)
    else $error("special bytes not selected");
  // Fetches and data accesses in RAM pick the RAM.
  ram_sel_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R04
    (req_i && a >= RAM_BASE && a <= RAM_END) |-> ram_sel_o)
    else $error("ram not selected");
  // Fetches and data accesses in program memory pick program memory.
  prog_sel_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R02
    (req_i && a >= PROG_BASE) |-> prog_sel_o)
    else $error("program memory not selected");
  // Every byte read returns a zero upper byte two cycles later.
  byte_read_zero_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R06
    (go && !we_i && byte_i) |=> ##1 (shared_data_bus_rd_o[15:8] == ZERO_BYTE && rvalid_o))
    else $error("byte read upper byte not zero");
  // A word write to a byte module enables the low lane only.
  byte_write_low_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R09
    (bper_sel_o && we_i && !byte_i) |-> (tgt_be_o == 2'h1))
    else $error("word write to byte module wrote upper byte");
  // An odd byte write lands on the upper lane.
  odd_byte_lane_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R13
    (tgt_we_o && byte_i && a[0]) |-> (tgt_be_o == 2'h2 && tgt_wdata_o[15:8] == shared_data_bus_wr_i[7:0]))
    else $error("odd byte not on upper lane");
  // Writes into holes in the map are dropped.
  unmapped_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R15
    (req_i && region == MAD_RG_NONE) |-> !tgt_we_o)
    else $error("unmapped write not dropped");
  // The highest program word is the highest priority vector.
  vec_top_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R03
    (req_i && !we_i && a == PROG_END - 17'h00001) |-> (vec_hit_o && vec_index_o == 4'hF))
    else $error("top vector index wrong");
  // At most one target is strobed in any cycle.
  sel_onehot_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R01
    $onehot0({sfb_sel_o, bper_sel_o, wper_sel_o, ram_sel_o, prog_sel_o}))
    else $error("more than one target strobed");
  // Without a request every strobe stays low.
  idle_quiet_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R01
    !req_i |-> !(sfb_sel_o || bper_sel_o || wper_sel_o || ram_sel_o || prog_sel_o || tgt_we_o))
    else $error("strobe without a request");
  // Accesses between RAM and program memory reach no target.
  gap_quiet_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R15
    (req_i && a > RAM_END && a < PROG_BASE) |->
      !(sfb_sel_o || bper_sel_o || wper_sel_o || ram_sel_o || prog_sel_o || tgt_we_o))
    else $error("gap access reached a target");
  // Reads from the gap complete with the open read value.
  gap_read_zero_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R15
    (req_i && !we_i && a > RAM_END && a < PROG_BASE) |=> ##1 (rvalid_o && shared_data_bus_rd_o == OPEN_READ))
    else $error("gap read value wrong");
  // Fetches above the peripheral range never request a reset.
  fetch_no_reset_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R04
    (req_i && fetch_i && a > WPER_END) |=> !fetch_reset_o)
    else $error("legal fetch raised reset");
  // A fetch is a read and never writes a target.
  fetch_no_write_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R02
    (req_i && fetch_i) |-> !tgt_we_o)
    else $error("fetch wrote a target");
  // A blocked fetch returns no read data.
  fetch_no_valid_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R14
    (req_i && fetch_i && a <= WPER_END) |=> ##1 !rvalid_o)
    else $error("blocked fetch returned data");
  // Writes never produce a read valid pulse.
  write_no_valid_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R01
    (req_i && we_i) |=> ##1 !rvalid_o)
    else $error("write returned read valid");
  // Program word reads pass the target word unchanged.
  prog_rd_data_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R02
    (prog_sel_o && !we_i && !byte_i) |=> ##1 (rvalid_o && shared_data_bus_rd_o == $past(prog_rdata_i)))
    else $error("program read data wrong");
  // RAM word reads pass the target word unchanged.
  ram_rd_data_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R04
    (ram_sel_o && !we_i && !byte_i) |=> ##1 (rvalid_o && shared_data_bus_rd_o == $past(ram_rdata_i)))
    else $error("ram read data wrong");
  // Word peripheral word reads pass the target word unchanged.
  wper_rd_data_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R05
    (wper_sel_o && !we_i && !byte_i) |=> ##1 (rvalid_o && shared_data_bus_rd_o == $past(wper_rdata_i)))
    else $error("word peripheral read data wrong");
  // Word reads of byte modules keep the register in the low byte.
  bper_rd_low_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R08
    (bper_sel_o && !we_i && !byte_i) |=> ##1 (shared_data_bus_rd_o[7:0] == $past(bper_rdata_i[7:0])))
    else $error("byte module low byte wrong");
  // An odd byte read takes the upper lane of the stored word.
  odd_byte_read_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R13
    (ram_sel_o && !we_i && byte_i && a[0]) |=> ##1 (shared_data_bus_rd_o[7:0] == $past(ram_rdata_i[15:8])))
    else $error("odd byte read lane wrong");
  // Word writes to RAM enable both lanes with data in place.
  ram_word_lanes_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R13
    (ram_sel_o && we_i && !byte_i) |-> (tgt_be_o == 2'h3 && tgt_wdata_o == shared_data_bus_wr_i))
    else $error("word write lanes wrong");
  // An even byte write lands on the lower lane.
  even_byte_lane_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R13
    (tgt_we_o && byte_i && !a[0]) |-> (tgt_be_o == 2'h1 && tgt_wdata_o[7:0] == shared_data_bus_wr_i[7:0]))
    else $error("even byte not on lower lane");
  // Word accesses reach the target on an even address.
  word_addr_even_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R12
    (go && !byte_i) |-> !tgt_addr_o[0])
    else $error("word target address odd");
  // Byte accesses reach the target at the requested address.
  byte_addr_pass_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R12
    (go && byte_i) |-> (tgt_addr_o == a))
    else $error("byte target address wrong");
  // Program words below the vector table are no vector hits.
  vec_range_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R03
    (prog_sel_o && a < VEC_BASE) |-> !vec_hit_o)
    else $error("vector hit below table");
  // The reset request only follows a low fetch.
  fetch_reset_pulse_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R14
    !(req_i && fetch_i && a <= WPER_END) |=> !fetch_reset_o)
    else $error("reset request without low fetch");
  // The lowest vector word has index zero.
  vec_low_index_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R03
    (prog_sel_o && a == VEC_BASE) |-> (vec_hit_o && vec_index_o == 4'h0))
    else $error("lowest vector index wrong");
endmodule
`default_nettype wire

// ---- test/mad_mem_model.sv ----
// Behavioural target memories that answer the decoder on its far side.
`default_nettype none
module mad_mem_model (
  input  wire logic             clk_i,
  input  wire logic [4:0]       sel_i,
  input  wire logic             we_i,
  input  wire logic [1:0]       be_i,
  input  wire logic [16:0]      addr_i,
  input  wire logic [15:0]      wdata_i,
  output logic      [4:0][15:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [logic [16:0]];
  logic [16:0] key;
  logic [15:0] q_r = 16'h5A5A;
  logic [4:0]  lsel_r = 5'h00;
  assign key = {addr_i[16:1], 1'b0};
  // Stores enabled lanes and returns the addressed word one cycle after the select.
  always @(posedge clk_i) begin
    lsel_r <= sel_i;
    q_r    <= ~q_r;
    if (sel_i != 5'h00 && we_i) begin
      if (!mem.exists(key)) mem[key] = 16'h0000;
      if (be_i[0]) mem[key][7:0] = wdata_i[7:0];
      if (be_i[1]) mem[key][15:8] = wdata_i[15:8];
    end else if (sel_i != 5'h00) begin
      q_r <= mem.exists(key) ? mem[key] : 16'hFFFF;
    end
  end
  // Unselected targets show changing data, so a stale value never passes as an answer.
  always_comb begin
    for (int k = 0; k < 5; k++) rdata_o[k] = lsel_r[k] ? q_r : ~q_r;
  end
endmodule
`default_nettype wire

// ---- test/mad_decoder_test.sv ----
// Self-checking testbench of the memory address map decoder.
`default_nettype none
module mad_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic arst_n_i, req, we, byt, fet, tw, hit, fr, rv, frq;
  logic [16:0] adr, ta, cta;
  logic [15:0] wd, rd, twd, rdo, cwd;
  logic [4:0] sel;
  logic [4:0][15:0] rdv;
  logic [1:0] be, tbe;
  logic [3:0] vi;
  logic s0, s1, s2, s3, s4, twe, vh;
  logic [3:0] vix;
  int err_count = 0;
  int check_count = 0;
  mad_decoder uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .req_i(req), .we_i(we), .byte_i(byt),
    .fetch_i(fet), .shared_address_bus_i(adr), .shared_data_bus_wr_i(wd), .shared_data_bus_rd_o(rdo),
    .rvalid_o(rv), .sfb_sel_o(s4), .bper_sel_o(s3), .wper_sel_o(s2), .ram_sel_o(s1), .prog_sel_o(s0),
    .vec_hit_o(vh), .vec_index_o(vix), .tgt_we_o(twe), .tgt_be_o(tbe), .tgt_addr_o(ta),
    .tgt_wdata_o(twd), .sfb_rdata_i(rdv[4]), .bper_rdata_i(rdv[3]), .wper_rdata_i(rdv[2]),
    .ram_rdata_i(rdv[1]), .prog_rdata_i(rdv[0]), .fetch_reset_o(frq));
  mad_mem_model mem (.clk_i(mclk_i), .sel_i({s4, s3, s2, s1, s0}), .we_i(twe), .be_i(tbe),
    .addr_i(ta), .wdata_i(twd), .rdata_o(rdv));
  // Free-running system clock.
  always #20 mclk_i = ~mclk_i;
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, s, e);
    end
  endtask
  // One access: strobes sampled in the request cycle, read data caught on the valid pulse.
  task automatic acc(input logic w, input logic b, input logic f, input logic [16:0] a, input logic [15:0] d);
    chk(f & a[0], 1'b0);
    chk(~b & a[0], 1'b0);
    {req, we, byt, fet, adr, wd} = {1'b1, w, b, f, a, d};
    #1 {sel, be, tw, hit, vi, cwd, cta} = {s4, s3, s2, s1, s0, tbe, twe, vh, vix, twd, ta};
    @(posedge mclk_i);
    #1 {req, we, byt, fet} = 4'h0;
    fr = frq;
    if (!w && !(f && a < 17'h00200)) begin
      chk(rv, 1'b0);
      @(posedge mclk_i);
      #1;
      chk(rv, 1'b1);
      rd = rdo;
    end
    @(posedge mclk_i);
    #1;
  endtask
  // RAM word and byte lanes in little-endian order, and a fetch from RAM.
  task automatic t_ram;
    acc(1, 0, 0, 17'h00200, 16'h1234);
    chk({sel, be, cta}, {5'b00010, 2'b11, 17'h00200});
    acc(1, 1, 0, 17'h00203, 16'h00AB);
    chk({be, cwd[15:8], cta}, {2'b10, 8'hAB, 17'h00203});
    acc(1, 1, 0, 17'h00204, 16'h00CD);
    chk({be, cwd[7:0], cta}, {2'b01, 8'hCD, 17'h00204});
    acc(0, 1, 0, 17'h00204, 16'h0000);
    chk(rd, 16'h00CD);
    acc(0, 0, 0, 17'h00202, 16'h0000);
    chk(rd, 16'hAB00);
    acc(0, 1, 0, 17'h00201, 16'h0000);
    chk(rd, 16'h0012);
    acc(0, 0, 1, 17'h00200, 16'h0000);
    chk({fr, rd}, {1'b0, 16'h1234});
  endtask
  // Word peripherals: word write, even byte read with zero upper byte.
  task automatic t_wper;
    acc(1, 0, 0, 17'h001FE, 16'hBEEF);
    chk(sel, 5'b00100);
    acc(0, 1, 0, 17'h001FE, 16'h0000);
    chk(rd, 16'h00EF);
  endtask
  // Byte peripherals: byte and word writes, word and byte reads.
  task automatic t_bper;
    acc(1, 1, 0, 17'h00011, 16'h0077);
    chk(sel, 5'b01000);
    acc(1, 0, 0, 17'h00010, 16'h5A3C);
    chk({be, cwd[7:0]}, {2'b01, 8'h3C});
    acc(0, 0, 0, 17'h00010, 16'h0000);
    chk(rd[7:0], 8'h3C);
    acc(0, 1, 0, 17'h00011, 16'h0000);
    chk(rd, 16'h0077);
    acc(0, 1, 0, 17'h000FF, 16'h0000);
    chk(sel, 5'b01000);
  endtask
  // Special function bytes with byte transfers only.
  task automatic t_sfb;
    acc(1, 1, 0, 17'h0000F, 16'h0099);
    chk({sel, be}, {5'b10000, 2'b10});
    acc(0, 1, 0, 17'h0000F, 16'h0000);
    chk(rd, 16'h0099);
  endtask
  // Program memory bounds and the vector table.
  task automatic t_prog;
    acc(0, 0, 0, 17'h1FFFE, 16'h0000);
    chk({sel, hit, vi, rd}, {5'b00001, 1'b1, 4'hF, 16'hFFFF});
    acc(0, 0, 0, 17'h1FFE0, 16'h0000);
    chk({hit, vi}, {1'b1, 4'h0});
    acc(0, 0, 0, 17'h1FFDE, 16'h0000);
    chk(hit, 1'b0);
    acc(0, 0, 1, 17'h1C000, 16'h0000);
    chk({sel, fr}, {5'b00001, 1'b0});
    acc(0, 0, 0, 17'h1BFFE, 16'h0000);
    chk(sel, 5'b00000);
  endtask
  // Fetches from the register and peripheral range request a reset.
  task automatic t_fetch;
    acc(0, 0, 1, 17'h00000, 16'h0000);
    chk({sel, fr}, {5'b00000, 1'b1});
    acc(0, 0, 1, 17'h001FE, 16'h0000);
    chk({sel, fr}, {5'b00000, 1'b1});
  endtask
  // Holes in the map drop writes and read as zero.
  task automatic t_open;
    acc(1, 0, 0, 17'h00400, 16'hDEAD);
    chk({sel, tw}, 6'h00);
    acc(0, 0, 0, 17'h00400, 16'h0000);
    chk(rd, 16'h0000);
    acc(0, 0, 0, 17'h003FE, 16'h0000);
    chk(sel, 5'b00010);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence after three cycles of reset.
  initial begin
    {arst_n_i, req, we, byt, fet, adr, wd} = '0;
    repeat (3) @(posedge mclk_i);
    #1 arst_n_i = 1'b1;
    t_ram();
    t_wper();
    t_bper();
    t_sfb();
    t_prog();
    t_fetch();
    t_open();
    results();
  end
  // Cuts a hang short well beyond the expected run time.
  initial begin
    #40000;
    err_count++;
    results();
  end
endmodule
`default_nettype wire
